// ### sim/sisc_checker.sv
// Port-level assertions for the sensor and servo block.
module sisc_checker #(
  parameter int unsigned FRAME_TICKS = 20000
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input sisc_pkg::sisc_addr_t reg_addr_i,
  input sisc_pkg::sisc_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input sisc_pkg::sisc_word_t reg_rdata_o,
  input wire logic ir_left_i,
  input wire logic ir_right_i,
  input wire logic button_a_i,
  input wire logic button_b_i,
  input wire logic button_c_i,
  input wire logic [4:0] servo_pwm_o,
  input wire logic irq_o
);
  import sisc_pkg::*;
  logic [2:0] btn;
  logic st_rd;
  logic [31:0] hi_q;
  assign btn = {button_a_i, button_b_i, button_c_i};
  assign st_rd = reg_rd_i && reg_addr_i == 8'h00;
  // A servo 0 pulse that filled the frame would never fall, so its run length is bounded.
  always_ff @(posedge sys_clk_i) begin
    hi_q <= (rst_i || !servo_pwm_o[0]) ? 32'h0 : hi_q + 32'h1;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not idle");
  chk_rst_quiet: assert property ($past(rst_i) |-> servo_pwm_o == 5'h0 && !irq_o)
    else $error("outputs active after reset");
  chk_ir_bits: assert property ($stable(ir_left_i)[*6] ##0 $stable(ir_right_i) ##0 st_rd
    |=> reg_rdata_o[0] == $past(ir_left_i) && reg_rdata_o[1] == $past(ir_right_i))
    else $error("proximity bits wrong");
  chk_button_level: assert property ($stable(btn)[*6] ##0 st_rd
    |=> reg_rdata_o[4:2] == $past(btn)) else $error("button level bits wrong");
  chk_press_once: assert property ($stable(btn)[*8] ##0 (st_rd && $past(reg_rd_i)
    && $past(reg_addr_i) == 8'h00) |=> reg_rdata_o[7:5] == 3'h0) else $error("press bit repeated");
  chk_high_byte: assert property ($past(st_rd) |-> reg_rdata_o[31:8] == 24'h0)
    else $error("status upper bits set");
  chk_unmapped: assert property (reg_rd_i && reg_addr_i[7:5] != 3'h0
    && reg_addr_i[4:2] > 3'h4 |=> reg_rdata_o == 32'h0) else $error("unmapped read data");
  chk_pulse_short: assert property (hi_q < FRAME_TICKS * 250)
    else $error("servo pulse fills frame");
  chk_irq_masked: assert property (reg_wr_i && reg_addr_i == 8'h08
    && reg_wdata_i[4:0] == 5'h0 |=> ##1 !irq_o) else $error("masked interrupt high");
endmodule

bind sisc_top sisc_checker #(.FRAME_TICKS(FRAME_TICKS)) u_chk (.sys_clk_i, .rst_i, .clk_en_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ir_left_i, .ir_right_i,
  .button_a_i, .button_b_i, .button_c_i, .servo_pwm_o, .irq_o);

// ### sim/sisc_pin_model.sv
// Button and proximity pins, high while pressed or while an object is seen.
module sisc_pin_model (
  input wire logic sys_clk_i,
  input wire logic [4:0] pat_i,
  output logic [4:0] pins_o
);
  logic [4:0] q = 5'h0;
  always @(posedge sys_clk_i) begin
    q <= pat_i;
  end
  assign pins_o = q;
endmodule

// ### sim/tb.sv
// Self-checking bench: register reads, sensor status, interrupt and servo pulses.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sisc_pkg::*;
  localparam int FT = 48;
  logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, irq_o;
  logic rd_q = 1'b0;
  sisc_addr_t reg_addr_i;
  sisc_word_t reg_wdata_i, reg_rdata_o, rng, exp_q[$];
  logic [4:0] pat, prev, r, ev, pins, servo_pwm_o;
  int error_cnt, checks, s, i, cnt[5];
  int stg[5] = '{5, 20, 40, 10, 100};
  int wid[5] = '{10, 20, 30, 10, FT - 1};
  sisc_top #(.FRAME_TICKS(FT)) DUT (.sys_clk_i, .rst_i, .clk_en_i(1'b1), .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ir_left_i(pins[0]), .ir_right_i(pins[1]),
    .button_c_i(pins[2]), .button_b_i(pins[3]), .button_a_i(pins[4]), .servo_pwm_o, .irq_o);
  sisc_pin_model u_pins (.sys_clk_i, .pat_i(pat), .pins_o(pins));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] ad(input int g, input int n);
    return 8'(g + 4 * n);
  endfunction
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    if (rd_q) begin
      if (exp_q.size() == 0) cmp("read queue", 32'h0, 32'h1);
      else cmp("read data", exp_q.pop_front(), reg_rdata_o);
    end
    rd_q <= reg_rd_i;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
  endtask
  task automatic idle(input int n);
    reg_rd_i <= 1'b0;
    reg_wr_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wait_pwm(input logic [4:0] v);
    int n;
    n = 0;
    while (servo_pwm_o !== v) begin
      if (n++ > FT * 250) begin
        error_cnt++;
        finish_test();
      end
      @(posedge sys_clk_i);
    end
  endtask
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, pat} = {1'b1, 47'h0};
    rng = 32'h40294d8c;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (s = 0; s < 5; s++) begin
      rd(ad(32, s), 32'h190);
      rd(ad(64, s), 32'h190);
      rd(ad(96, s), 32'h0834_0190);
    end
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h74, 32'h0);
    $display("test reset values done");
    for (s = 0; s < 5; s++) begin
      rng = xs(rng);
      wr(ad(32, s), rng);
      cnt[s] = int'(rng[11:0]);
      for (i = 0; i < 5; i++) rd(ad(32, i), i > s ? 32'h190 : 32'(cnt[i]));
    end
    $display("test single position done");
    prev = 5'h0;
    for (i = 0; i < 32; i++) begin
      r = 5'(i * 7);
      pat <= r;
      idle(8);
      ev = r & ~prev;
      rd(8'h00, {24'h0, ev[4:2], r});
      rd(8'h00, {27'h0, r});
      rd(8'h04, {27'h0, ev});
      prev = r;
    end
    pat <= 5'h0;
    idle(8);
    wr(8'h08, 32'h1);
    pat <= 5'h1;
    idle(8);
    cmp("irq", 32'h1, 32'(irq_o));
    wr(8'h08, 32'h0);
    idle(3);
    cmp("irq", 32'h0, 32'(irq_o));
    wr(8'h08, 32'h1);
    idle(3);
    cmp("irq", 32'h1, 32'(irq_o));
    rd(8'h04, 32'h1);
    idle(3);
    cmp("irq", 32'h0, 32'(irq_o));
    $display("test status and interrupt done");
    for (s = 0; s < 5; s++) begin
      wr(ad(96, s), s == 4 ? 32'h0834_000a : 32'h001e_000a);
      wr(ad(64, s), 32'(stg[s]));
      rd(ad(96, s), s == 4 ? 32'h0834_000a : 32'h001e_000a);
    end
    wr(8'h0c, 32'h0);
    idle(FT * 250 + 10);
    wait_pwm(5'h0);
    wait_pwm(5'h1f);
    for (s = 0; s < 5; s++) cnt[s] = 0;
    repeat (FT * 250) begin
      for (s = 0; s < 5; s++) cnt[s] += int'(servo_pwm_o[s]);
      @(posedge sys_clk_i);
    end
    for (s = 0; s < 5; s++) cmp("pulse width", 32'(wid[s] * 250), 32'(cnt[s]));
    $display("test servo pulses done");
    finish_test();
  end
endmodule

// ### src/sisc_map.svh
// Address map, field positions, reset values and timing figures of the sensor and servo block.
// How it works
// RULE_01: Status bit 0 is left proximity, bit 1 right proximity, one means object.
// RULE_02: Status bits 2, 3, 4 show buttons c, b, a level, one pressed.
// RULE_03: A level bit follows its button, high while held, low once released.
// RULE_04: Status bits 5, 6, 7 give press versions of buttons c, b, a.
// RULE_05: A press bit reads one once per press, then zero until next press.
// RULE_06: One commit write moves five staged positions into all servos together.
// RULE_07: Positions from 400 to 2100 are accepted by default.
// RULE_08: A single position write changes one servo and leaves the others unchanged.
// RULE_09: Each servo has its own minimum and maximum, resetting to 400 and 2100.
// RULE_10: Servo index 0 to 4 selects exactly one servo; other indices are unmapped.
// RULE_11: Position sets pulse width, and the pulse never fills the whole period.
// RULE_12: The host spaces status requests, roughly 100 ms apart.
// RULE_13: Positions outside a servo's limits are clamped to the nearer limit.
`ifndef SISC_MAP_SVH
`define SISC_MAP_SVH

`define SISC_OFF_STATUS 8'h00
`define SISC_OFF_INT_STAT 8'h04
`define SISC_OFF_INT_MASK 8'h08
`define SISC_OFF_COMMIT 8'h0c
`define SISC_GRP_CTRL 3'h0
`define SISC_GRP_POS 3'h1
`define SISC_GRP_STAGE 3'h2
`define SISC_GRP_LIM 3'h3

`define SISC_N_SERVO 5
`define SISC_N_PIN 5
`define SISC_N_BTN 3
`define SISC_BTN_LSB 2

`define SISC_LIM_MIN_LSB 0
`define SISC_LIM_MAX_LSB 16
`define SISC_LIM_MIN_RST 12'h190
`define SISC_LIM_MAX_RST 12'h834
`define SISC_POS_RST 12'h190

`define SISC_CLK_PERIOD_NS 4
`define SISC_TICK_NS 1000
`define SISC_TICK_CYCLES ((`SISC_TICK_NS + `SISC_CLK_PERIOD_NS - 1) / `SISC_CLK_PERIOD_NS)
`define SISC_FRAME_US 20000
`define SISC_FRAME_TICKS (`SISC_FRAME_US * 1000 / `SISC_TICK_NS)

`endif

// ### src/sisc_pkg.sv
// Types shared by the sensor and servo block.
package sisc_pkg;
  typedef logic [7:0] sisc_addr_t;
  typedef logic [31:0] sisc_word_t;
  typedef logic [11:0] sisc_pos_t;
  typedef logic [14:0] sisc_frame_t;
  typedef logic [7:0] sisc_tick_t;
endpackage

// ### src/sisc_top.sv
// Sensor status byte, interrupt flags and five-channel servo pulse generator.
`include "sisc_map.svh"

module sisc_top #(
  parameter int unsigned FRAME_TICKS = `SISC_FRAME_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input sisc_pkg::sisc_addr_t reg_addr_i,
  input sisc_pkg::sisc_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output sisc_pkg::sisc_word_t reg_rdata_o,
  input wire logic ir_left_i,
  input wire logic ir_right_i,
  input wire logic button_a_i,
  input wire logic button_b_i,
  input wire logic button_c_i,
  output logic [4:0] servo_pwm_o,
  output logic irq_o
);
  import sisc_pkg::*;

  // Pin order matches the low five status bits, so the status byte is a plain concatenation.
  logic [`SISC_N_PIN-1:0] pin_raw;
  assign pin_raw = {button_a_i, button_b_i, button_c_i, ir_right_i, ir_left_i};

  logic [`SISC_N_PIN-1:0] sync1_q;
  logic [`SISC_N_PIN-1:0] sync2_q;
  logic [`SISC_N_PIN-1:0] sync3_q;
  logic [`SISC_N_PIN-1:0] filt_q;
  logic [`SISC_N_PIN-1:0] filt_d;
  logic [`SISC_N_PIN-1:0] rise;

  logic [`SISC_N_BTN-1:0] press_q;
  logic [`SISC_N_BTN-1:0] press_d;
  logic [`SISC_N_PIN-1:0] int_stat_q;
  logic [`SISC_N_PIN-1:0] int_stat_d;
  logic [`SISC_N_PIN-1:0] int_mask_q;
  logic irq_q;

  sisc_word_t rdata_q;
  sisc_word_t rd_word;

  sisc_tick_t tick_q;
  sisc_frame_t frame_q;
  logic tick;
  logic frame_end;
  logic [`SISC_N_SERVO-1:0] pwm_q;
  logic [`SISC_N_SERVO-1:0] pwm_d;

  sisc_pos_t pos_rd [`SISC_N_SERVO];
  sisc_pos_t stage_rd [`SISC_N_SERVO];
  sisc_pos_t min_rd [`SISC_N_SERVO];
  sisc_pos_t max_rd [`SISC_N_SERVO];

  // Register decode.
  logic [2:0] grp;
  logic [2:0] idx;
  logic [2:0] idx_s;
  logic idx_ok;
  logic aligned;
  logic wr_pos;
  logic wr_stage;
  logic wr_lim;
  logic wr_commit;
  logic wr_mask;
  logic rd_status;
  logic rd_int;

  assign grp = reg_addr_i[7:5];
  assign idx = reg_addr_i[4:2];
  assign aligned = (reg_addr_i[1:0] == 2'h0);
  assign idx_ok = aligned && (idx < 3'(`SISC_N_SERVO)); // [RULE_10]
  assign idx_s = idx_ok ? idx : 3'h0;
  assign wr_pos = reg_wr_i && (grp == `SISC_GRP_POS) && idx_ok; // [RULE_08]
  assign wr_stage = reg_wr_i && (grp == `SISC_GRP_STAGE) && idx_ok;
  assign wr_lim = reg_wr_i && (grp == `SISC_GRP_LIM) && idx_ok; // [RULE_09]
  assign wr_commit = reg_wr_i && (reg_addr_i == `SISC_OFF_COMMIT); // [RULE_06]
  assign wr_mask = reg_wr_i && (reg_addr_i == `SISC_OFF_INT_MASK);
  assign rd_status = reg_rd_i && (reg_addr_i == `SISC_OFF_STATUS);
  assign rd_int = reg_rd_i && (reg_addr_i == `SISC_OFF_INT_STAT);

  // Input conditioning: three stages, and a change is taken only when stages two and three agree.
  // This rejects a single-cycle glitch but does not debounce mechanical bounce.
  generate
    for (genvar p = 0; p < `SISC_N_PIN; p++) begin : g_pin
      assign filt_d[p] = (sync2_q[p] == sync3_q[p]) ? sync2_q[p] : filt_q[p];
    end
  endgenerate

  assign rise = filt_d & ~filt_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else if (clk_en_i) begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d; // [RULE_01] [RULE_02] [RULE_03]
    end
  end

  // Press bits are sticky until the status byte is read; a new press in the read cycle survives.
  assign press_d = rise[`SISC_BTN_LSB +: `SISC_N_BTN]
                 | (press_q & ~{`SISC_N_BTN{rd_status}}); // [RULE_04] [RULE_05]
  assign int_stat_d = rise | (int_stat_q & ~{`SISC_N_PIN{rd_int}});

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      press_q <= '0;
      int_stat_q <= '0;
      int_mask_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en_i) begin
      press_q <= press_d; // [RULE_05]
      int_stat_q <= int_stat_d;
      if (wr_mask) begin
        int_mask_q <= reg_wdata_i[`SISC_N_PIN-1:0];
      end
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  // Pulse timebase: one tick per position unit, one frame per servo period.
  assign tick = (tick_q == 8'(`SISC_TICK_CYCLES - 1));
  assign frame_end = tick && (frame_q == 15'(FRAME_TICKS - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_q <= '0;
      frame_q <= '0;
    end else if (clk_en_i) begin
      tick_q <= tick ? 8'h00 : tick_q + 8'h01;
      if (frame_end) begin
        frame_q <= '0;
      end else if (tick) begin
        frame_q <= frame_q + 15'h0001;
      end
    end
  end

  // Per-servo storage, clamping and pulse compare.
  generate
    for (genvar s = 0; s < `SISC_N_SERVO; s++) begin : g_servo
      sisc_pos_t pos_q;
      sisc_pos_t stage_q;
      sisc_pos_t min_q;
      sisc_pos_t max_q;
      sisc_pos_t lo;
      sisc_pos_t eff;
      sisc_frame_t eff_w;
      sisc_frame_t cap;
      sisc_frame_t width_q;
      sisc_frame_t width_d;
      logic sel;

      assign sel = (idx_s == 3'(s));
      assign lo = (pos_q < min_q) ? min_q : pos_q; // [RULE_13]
      assign eff = (lo > max_q) ? max_q : lo; // [RULE_13]
      assign eff_w = {3'h0, eff};
      // Capping at one tick short of the frame keeps every period ending low.
      assign cap = 15'(FRAME_TICKS - 1);
      assign width_d = (eff_w > cap) ? cap : eff_w; // [RULE_11]
      assign pwm_d[s] = (frame_q < width_q); // [RULE_11]

      assign pos_rd[s] = pos_q;
      assign stage_rd[s] = stage_q;
      assign min_rd[s] = min_q;
      assign max_rd[s] = max_q;

      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          pos_q <= `SISC_POS_RST;
          stage_q <= `SISC_POS_RST;
          min_q <= `SISC_LIM_MIN_RST; // [RULE_07] [RULE_09]
          max_q <= `SISC_LIM_MAX_RST; // [RULE_07] [RULE_09]
          width_q <= '0;
        end else if (clk_en_i) begin
          if (wr_commit) begin
            pos_q <= stage_q; // [RULE_06]
          end else if (wr_pos && sel) begin
            pos_q <= reg_wdata_i[11:0]; // [RULE_08]
          end
          if (wr_stage && sel) begin
            stage_q <= reg_wdata_i[11:0];
          end
          if (wr_lim && sel) begin
            min_q <= reg_wdata_i[`SISC_LIM_MIN_LSB +: 12]; // [RULE_09]
            max_q <= reg_wdata_i[`SISC_LIM_MAX_LSB +: 12]; // [RULE_09]
          end
          // Width changes only at a frame boundary so no pulse is cut short.
          if (frame_end) begin
            width_q <= width_d;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwm_q <= '0;
    end else if (clk_en_i) begin
      pwm_q <= pwm_d;
    end
  end

  // Read selection; unmapped addresses read as zero.
  sisc_word_t status_word;
  sisc_word_t ctrl_word;
  sisc_word_t lim_word;
  sisc_word_t grp_word;

  assign status_word = {24'h000000, press_q, filt_q}; // [RULE_01] [RULE_02] [RULE_04]
  assign ctrl_word = (reg_addr_i == `SISC_OFF_STATUS) ? status_word
                   : (reg_addr_i == `SISC_OFF_INT_STAT) ? {27'h0, int_stat_q}
                   : (reg_addr_i == `SISC_OFF_INT_MASK) ? {27'h0, int_mask_q}
                   : 32'h00000000;
  assign lim_word = {4'h0, max_rd[idx_s], 4'h0, min_rd[idx_s]};
  assign grp_word = (grp == `SISC_GRP_POS) ? {20'h00000, pos_rd[idx_s]}
                  : (grp == `SISC_GRP_STAGE) ? {20'h00000, stage_rd[idx_s]}
                  : (grp == `SISC_GRP_LIM) ? lim_word
                  : 32'h00000000;
  assign rd_word = (grp == `SISC_GRP_CTRL) ? ctrl_word
                 : idx_ok ? grp_word
                 : 32'h00000000;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (clk_en_i) begin
      rdata_q <= reg_rd_i ? rd_word : 32'h00000000;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign servo_pwm_o = pwm_q;
  assign irq_o = irq_q;

endmodule
